// >>> core/pin_route_pkg.sv
// Purpose: constants for the input side of the pin routing matrix
// Assumes: classic Wishbone slave, 32-bit data, 16-bit registers
// Notes:   register word index times four gives the byte address
package pin_route_pkg;

  localparam int SEL_W     = 6;
  localparam int NUM_PINS  = 33;
  localparam int NUM_BIDIR = 29;
  localparam int NUM_REGS  = 19;
  localparam int NUM_FUNCS = 2 * NUM_REGS;
  localparam int ADR_W     = 8;
  localparam int LO_LSB    = 0;
  localparam int HI_LSB    = 8;
  localparam int REG_W     = 16;

  localparam logic [5:0] SEL_NONE = 6'h3F;
  localparam logic [15:0] SEL_RESET = 16'h3F3F;

  // Printed register numbers, in table order
  localparam int REG_NUM [NUM_REGS] = '{0, 1, 2, 3, 5, 6, 7, 8, 11, 12,
                                        18, 19, 20, 21, 22, 23, 25, 28, 29};

  // Word index 32 holds the lock, word index 33 the implemented-pin status
  localparam logic [5:0] LOCK_IDX = 6'h20;
  localparam logic [5:0] STAT_IDX = 6'h21;
  localparam int LOCK_BIT = 0;

  // Function slot = 2 * table position + (high field)
  localparam int F_OC_TRIG1 = 0;
  localparam int F_OC_TRIG2 = 5;
  localparam int F_TIMER_B  = 6;
  localparam int F_TIMER_C  = 7;
  localparam int F_OC_FLT_A = 16;
  localparam int F_OC_FLT_B = 17;
  localparam int F_SP1_DATA = 24;
  localparam int F_SP1_CLK  = 25;
  localparam int F_SP1_SEL  = 26;
  localparam int F_SP2_DATA = 28;
  localparam int F_SP2_CLK  = 29;
  localparam int F_SP2_SEL  = 30;
  localparam int F_GEN_TMR  = 31;
  localparam int F_SP3_DATA = 34;
  localparam int F_SP3_CLK  = 35;
  localparam int F_SP3_SEL  = 36;

endpackage

// >>> core/route_sync_if.sv
// Purpose: carries raw pin levels into the synchroniser
// Assumes: one clock domain on the consuming side
// Notes:   synced levels are read by the router only
`timescale 1ns/1ns
interface route_sync_if #(parameter int N = 33);
  logic [N-1:0] raw;
  logic [N-1:0] synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface

// >>> core/pin_sync.sv
// Purpose: two-stage synchroniser for every routable pin
// Assumes: pins are asynchronous to clk_i
// Notes:   the first stage feeds the second stage only
`timescale 1ns/1ns
module pin_sync #(
  parameter int N = 33
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  route_sync_if.snk  sif
);
  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] stab;
  } sync_st_t;

  sync_st_t st_r;
  sync_st_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = sif.raw;
    st_nxt.stab = st_r.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sif.synced = st_r.stab;
endmodule

// >>> core/input_pin_router.sv
// Purpose: routes remappable pin levels onto peripheral inputs
// Assumes: classic Wishbone slave; pins asynchronous to clk_i
// Notes:   output source encoding and unlock sequence live elsewhere
//
// Operation
// - Pins 0-28 bidirectional, 29-32 input only
// - Input-only pins never take routed outputs
// - Fixed-pin functions stay outside this matrix
// - Routed inputs have no default pin
// - Fixed peripherals keep their default pin
// - Routed outputs override port and parallel drivers
// - Fixed special outputs beat routed outputs
// - Input routing never touches the output buffer
// - Analog mode on a pin blocks routed input
// - Six-bit field value n selects pin n
// - Fields sit at bits 5:0 and 13:8
// - Valid values limited to implemented pins
// - Input and output routing registers are separate
// - Trigger 1 reg0 low, trigger 2 reg2 high
// - Timer clocks from reg23 high, reg3 fields
// - Fault A reg11 low, fault B high
// - Serial port 1 from reg20, reg21 low
// - Serial port 2 from reg22, reg23 low
// - Serial port 3 from reg28, reg29 low
// - At most 44 routable device pins
// - Unimplemented pin selection gives no input
// - Lock set makes writes complete without effect; here this covers the routing registers only, and the lock word stays writable
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
module input_pin_router #(
  parameter logic [32:0] PIN_IMPL = 33'h1_FFFF_FFFF
) (
  input  wire logic                                    clk_i,
  input  wire logic                                    rst_i,
  input  wire logic [7:0]                              adr_i,
  input  wire logic [31:0]                             dat_i,
  output logic      [31:0]                             dat_o,
  input  wire logic                                    we_i,
  input  wire logic [3:0]                              sel_i,
  input  wire logic                                    cyc_i,
  input  wire logic                                    stb_i,
  output logic                                         ack_o,
  input  wire logic [pin_route_pkg::NUM_PINS-1:0]      pin_level_i,
  input  wire logic [pin_route_pkg::NUM_PINS-1:0]      pin_analog_i,
  output logic      [pin_route_pkg::NUM_FUNCS-1:0]     periph_in_o,
  output logic                                         oc_trigger_in_1_o,
  output logic                                         oc_trigger_in_2_o,
  output logic                                         timer_b_ext_clk_o,
  output logic                                         timer_c_ext_clk_o,
  output logic                                         generic_timer_ext_clk_o,
  output logic                                         oc_fault_in_a_o,
  output logic                                         oc_fault_in_b_o,
  output logic                                         serial_port1_data_in_o,
  output logic                                         serial_port1_clk_in_o,
  output logic                                         serial_port1_sel_in_o,
  output logic                                         serial_port2_data_in_o,
  output logic                                         serial_port2_clk_in_o,
  output logic                                         serial_port2_sel_in_o,
  output logic                                         serial_port3_data_in_o,
  output logic                                         serial_port3_clk_in_o,
  output logic                                         serial_port3_sel_in_o,
  output logic                                         routing_write_lock_o
);
  localparam int NP = pin_route_pkg::NUM_PINS;
  localparam int NF = pin_route_pkg::NUM_FUNCS;
  localparam int NR = pin_route_pkg::NUM_REGS;
  localparam int SW = pin_route_pkg::SEL_W;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [NR-1:0][15:0] sel;
    logic                lock;
    logic                ack;
    logic [31:0]         rdata;
    logic [NF-1:0]       routed;
  } rtr_st_t;

  rtr_st_t st_r;
  rtr_st_t st_nxt;

  route_sync_if #(.N(NP)) sif ();

  // Two flops per pin before any routing logic
  pin_sync #(.N(NP)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif)
  );
  assign sif.raw = pin_level_i;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  logic [5:0] word_idx;
  logic       req;
  logic       reg_hit;
  logic [4:0] reg_pos;
  logic       is_lock;
  logic       is_stat;

  assign word_idx = adr_i[7:2];
  assign req      = cyc_i && stb_i && !st_r.ack;
  assign is_lock  = (word_idx == pin_route_pkg::LOCK_IDX);
  assign is_stat  = (word_idx == pin_route_pkg::STAT_IDX);

  always_comb begin
    reg_hit = 1'b0;
    reg_pos = '0;
    for (int i = 0; i < NR; i++) begin
      if (int'(word_idx) == pin_route_pkg::REG_NUM[i]) begin
        reg_hit = 1'b1;
        reg_pos = 5'(i);
      end
    end
  end

  // ------------------------------------------------------------------
  // Per-function selection
  // ------------------------------------------------------------------
  logic [NF-1:0][SW-1:0] fsel;
  logic [NF-1:0]         route_nxt;

  for (genvar f = 0; f < NF; f++) begin : g_func
    localparam int RP  = f / 2;
    localparam int LSB = (f % 2 == 1) ? pin_route_pkg::HI_LSB
                                      : pin_route_pkg::LO_LSB;
    logic valid;
    assign fsel[f] = st_r.sel[RP][LSB +: SW];
    // Only implemented pins are valid sources
    assign valid = (fsel[f] < SW'(NP)) && PIN_IMPL[fsel[f]];
    // Invalid pin or analog pin yields a steady low
    assign route_nxt[f] = valid && !pin_analog_i[fsel[f]]
                          && sif.synced[fsel[f]];
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.ack    = req;
    st_nxt.routed = route_nxt;
    if (req && !we_i) begin
      st_nxt.rdata = '0;
      if (reg_hit) begin
        st_nxt.rdata[15:0] = st_r.sel[reg_pos];
      end else if (is_lock) begin
        st_nxt.rdata[pin_route_pkg::LOCK_BIT] = st_r.lock;
      end else if (is_stat) begin
        // Bit 32 of the map does not fit the data bus
        st_nxt.rdata = 32'(PIN_IMPL);
      end
    end
    if (req && we_i) begin
      if (reg_hit && !st_r.lock) begin
        if (sel_i[0]) begin
          st_nxt.sel[reg_pos][pin_route_pkg::LO_LSB +: SW] =
            dat_i[pin_route_pkg::LO_LSB +: SW];
        end
        if (sel_i[1]) begin
          st_nxt.sel[reg_pos][pin_route_pkg::HI_LSB +: SW] =
            dat_i[pin_route_pkg::HI_LSB +: SW];
        end
      end
      if (is_lock && sel_i[0]) begin
        st_nxt.lock = dat_i[pin_route_pkg::LOCK_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r        <= '0;
      st_r.sel    <= {NR{pin_route_pkg::SEL_RESET}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign ack_o                = st_r.ack;
  assign dat_o                = st_r.rdata;
  assign routing_write_lock_o = st_r.lock;
  // Input side only: no pad driver or buffer enable leaves here
  assign periph_in_o          = st_r.routed;
  assign oc_trigger_in_1_o =
    st_r.routed[pin_route_pkg::F_OC_TRIG1];
  assign oc_trigger_in_2_o =
    st_r.routed[pin_route_pkg::F_OC_TRIG2];
  assign timer_b_ext_clk_o =
    st_r.routed[pin_route_pkg::F_TIMER_B];
  assign timer_c_ext_clk_o =
    st_r.routed[pin_route_pkg::F_TIMER_C];
  assign generic_timer_ext_clk_o =
    st_r.routed[pin_route_pkg::F_GEN_TMR];
  assign oc_fault_in_a_o =
    st_r.routed[pin_route_pkg::F_OC_FLT_A];
  assign oc_fault_in_b_o =
    st_r.routed[pin_route_pkg::F_OC_FLT_B];
  assign serial_port1_data_in_o =
    st_r.routed[pin_route_pkg::F_SP1_DATA];
  assign serial_port1_clk_in_o =
    st_r.routed[pin_route_pkg::F_SP1_CLK];
  assign serial_port1_sel_in_o =
    st_r.routed[pin_route_pkg::F_SP1_SEL];
  assign serial_port2_data_in_o =
    st_r.routed[pin_route_pkg::F_SP2_DATA];
  assign serial_port2_clk_in_o =
    st_r.routed[pin_route_pkg::F_SP2_CLK];
  assign serial_port2_sel_in_o =
    st_r.routed[pin_route_pkg::F_SP2_SEL];
  assign serial_port3_data_in_o =
    st_r.routed[pin_route_pkg::F_SP3_DATA];
  assign serial_port3_clk_in_o =
    st_r.routed[pin_route_pkg::F_SP3_CLK];
  assign serial_port3_sel_in_o =
    st_r.routed[pin_route_pkg::F_SP3_SEL];

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_locked_write;
    cyc_i && stb_i && !st_r.ack && we_i && reg_hit && st_r.lock;
  endsequence

  sequence s_open_write;
    cyc_i && stb_i && !st_r.ack && we_i && reg_hit && !st_r.lock
      && sel_i[0];
  endsequence

  ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  ack_follows_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not answered next cycle");

  lock_blocks_write_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    s_locked_write |=> $stable(st_r.sel))
    else $error("routing register changed while locked");

  open_write_lands_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    s_open_write |=> (st_r.sel[$past(reg_pos)][5:0] == $past(dat_i[5:0])))
    else $error("unlocked write did not land");

  reserved_bits_zero_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ##1 (st_r.sel[0][7:6] == 2'h0) && (st_r.sel[0][15:14] == 2'h0))
    else $error("bits outside the fields became set");

  invalid_sel_low_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (fsel[pin_route_pkg::F_OC_TRIG1] >= SW'(NP)) |=> !oc_trigger_in_1_o)
    else $error("invalid selection produced a level");

  analog_blocks_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (fsel[pin_route_pkg::F_SP1_CLK] < SW'(NP))
      && pin_analog_i[fsel[pin_route_pkg::F_SP1_CLK]]
      |=> !serial_port1_clk_in_o)
    else $error("analog pin leaked into routed input");

  // Pin 0 routed, digital, sync chain out of reset for two edges
  sequence s_pin0_to_sp2;
    (fsel[pin_route_pkg::F_SP2_DATA] == 6'h00) && PIN_IMPL[0]
      && !pin_analog_i[0] && !$past(rst_i) && !$past(rst_i, 2);
  endsequence

  sync_latency_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    s_pin0_to_sp2
      |=> (serial_port2_data_in_o == $past(pin_level_i[0], 3)))
    else $error("routed level does not follow pin after sync");

  reset_unrouted_a: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (periph_in_o == '0) && !routing_write_lock_o)
    else $error("peripheral input routed out of reset");

  sequence s_fault_a_unimpl;
    (fsel[pin_route_pkg::F_OC_FLT_A] < SW'(NP))
      && !PIN_IMPL[fsel[pin_route_pkg::F_OC_FLT_A]];
  endsequence

  sequence s_open_high_write;
    req && we_i && reg_hit && !st_r.lock && sel_i[1];
  endsequence

  sequence s_unmapped_read;
    req && !we_i && !reg_hit && !is_lock && !is_stat;
  endsequence

  unimpl_pin_low_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    s_fault_a_unimpl |=> !oc_fault_in_a_o)
    else $error("unimplemented pin produced a level");

  high_write_lands_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    s_open_high_write
      |=> (st_r.sel[$past(reg_pos)][pin_route_pkg::HI_LSB +: SW]
           == $past(dat_i[pin_route_pkg::HI_LSB +: SW])))
    else $error("unlocked high field write did not land");

  unmapped_zero_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    s_unmapped_read |=> (dat_o == '0))
    else $error("unmapped word read back nonzero");

  stat_reads_impl_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (req && !we_i && is_stat) |=> (dat_o == 32'(PIN_IMPL)))
    else $error("status word differs from implemented pins");

  lock_write_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (req && we_i && is_lock && sel_i[0])
      |=> (routing_write_lock_o
           == $past(dat_i[pin_route_pkg::LOCK_BIT])))
    else $error("lock bit did not take written value");

  reset_quiet_a: assert property (@(posedge clk_i)
    rst_i |=> !ack_o && (dat_o == '0))
    else $error("bus outputs not cleared by reset");

endmodule

// >>> testbench/pad_model.sv
// Purpose: pad cells feeding routable pin levels
// Assumes: levels and analog flags set by the bench
// Notes:   one flop per pad, unrelated to any setup
`timescale 1ns/1ns
module pad_model (
  input  wire logic        clk_i,
  input  wire logic [32:0] lvl_i,
  input  wire logic [32:0] ana_i,
  output logic      [32:0] pin_level_o,
  output logic      [32:0] pin_analog_o
);
  // ----
  // Pads 0-28 two-way, 29-32 input only
  // ----
  always @(posedge clk_i) begin
    pin_level_o  <= lvl_i;
    pin_analog_o <= ana_i;
  end
endmodule

// >>> testbench/tb.sv
// Purpose: self-checking bench for input_pin_router
// Assumes: pins 16-25 left out of the variant
// Notes:   reads noted in a queue, checked on ack
`timescale 1ns/1ns
module tb;
  localparam logic [32:0] IMPL = 33'h1_FC00_FFFF;
  localparam int NS [16] = '{0, 5, 6, 7, 16, 17, 24, 25, 26,
                             28, 29, 30, 31, 34, 35, 36};
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0;
  logic [31:0] dat_o;
  logic        we = 0;
  logic [3:0]  sel = 0;
  logic        cyc = 0;
  logic        stb = 0;
  logic        ack_o;
  logic [32:0] lvl = 0;
  logic [32:0] ana = 0;
  logic [32:0] pin_l;
  logic [32:0] pin_a;
  logic [37:0] pi;
  logic [15:0] nm;
  logic        lk;
  logic [31:0] seed = 32'hC1B4477A;
  logic [5:0]  pin_of [38];
  logic [31:0] exq [$];
  int          num_errors = 0;
  int          total_checks = 0;

  always #4 clk_i = ~clk_i;

  pad_model pad_model_inst (.clk_i(clk_i), .lvl_i(lvl), .ana_i(ana),
    .pin_level_o(pin_l), .pin_analog_o(pin_a));

  input_pin_router #(.PIN_IMPL(IMPL)) input_pin_router_inst (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat),
    .dat_o(dat_o), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb),
    .ack_o(ack_o), .pin_level_i(pin_l), .pin_analog_i(pin_a),
    .periph_in_o(pi), .oc_trigger_in_1_o(nm[0]),
    .oc_trigger_in_2_o(nm[1]), .timer_b_ext_clk_o(nm[2]),
    .timer_c_ext_clk_o(nm[3]), .oc_fault_in_a_o(nm[4]),
    .oc_fault_in_b_o(nm[5]), .serial_port1_data_in_o(nm[6]),
    .serial_port1_clk_in_o(nm[7]), .serial_port1_sel_in_o(nm[8]),
    .serial_port2_data_in_o(nm[9]), .serial_port2_clk_in_o(nm[10]),
    .serial_port2_sel_in_o(nm[11]), .generic_timer_ext_clk_o(nm[12]),
    .serial_port3_data_in_o(nm[13]), .serial_port3_clk_in_o(nm[14]),
    .serial_port3_sel_in_o(nm[15]), .routing_write_lock_o(lk));

  // ----
  // Helpers
  // ----
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic ex(input logic [5:0] p);
    return p < 33 && IMPL[p] && !ana[p] && lvl[p];
  endfunction

  task wrap_up();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [37:0] s, input logic [37:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          input logic [3:0] s, input logic [31:0] e);
    int n;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    if (!w) exq.push_back(e);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      wrap_up();
    end
    cyc <= 0;
    stb <= 0;
  endtask

  task rt();
    repeat (6) @(posedge clk_i);
    for (int f = 0; f < 38; f++) chk(pi[f], ex(pin_of[f]));
    for (int k = 0; k < 16; k++) chk(nm[k], ex(pin_of[NS[k]]));
  endtask

  always @(posedge clk_i)
    if (ack_o === 1'b1 && we === 1'b0 && exq.size() > 0)
      chk(dat_o, exq.pop_front());

  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] r;
    logic [7:0]  a;
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk(pi, 0);
    wb(0, 8'h00, 0, 4'hF, 32'h3F3F);
    for (int t = 0; t < 19; t++) begin
      r = rnd();
      if (t == 8) r[5:0] = 6'h12;
      if (t == 12) r[13:8] = 6'h1F;
      if (t == 14) r[5:0] = 6'h00;
      pin_of[2*t]   = r[5:0];
      pin_of[2*t+1] = r[13:8];
      a = 8'(4 * pin_route_pkg::REG_NUM[t]);
      wb(1, a, r, 4'h3, 0);
      wb(0, a, 0, 4'hF, {18'h0, r[13:8], 2'b0, r[5:0]});
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      lvl <= 33'(i == 0 ? '1 : {rnd(), rnd()});
      ana <= (i == 2) ? {33{1'b1}}
                      : 33'(i == 1 ? 0 : rnd() & rnd() & rnd());
      rt();
    end
    pin_of[1] = 6'h05;
    wb(1, 8'h00, 32'h0505, 4'h2, 0);
    wb(0, 8'h00, 0, 4'hF, {18'h0, pin_of[1], 2'b0, pin_of[0]});
    rt();
    wb(1, 8'h80, 1, 4'hF, 0);
    wb(0, 8'h80, 0, 4'hF, 1);
    chk(lk, 1);
    wb(1, 8'h00, 0, 4'hF, 0);
    wb(0, 8'h00, 0, 4'hF, {18'h0, pin_of[1], 2'b0, pin_of[0]});
    wb(1, 8'h80, 0, 4'hF, 0);
    wb(1, 8'h10, 32'hFFFF, 4'hF, 0);
    wb(0, 8'h10, 0, 4'hF, 0);
    wb(0, 8'h84, 0, 4'hF, IMPL[31:0]);
    // Reset in mid-run clears lock and returns fields to 3F3F
    wb(1, 8'h80, 1, 4'hF, 0);
    @(posedge clk_i);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk(lk, 0);
    chk(pi, 0);
    wb(0, 8'h00, 0, 4'hF, 32'h3F3F);
    repeat (2) @(posedge clk_i);
    chk(exq.size(), 0);
    wrap_up();
  end
endmodule
